//--- verilog/tpc_pkg.sv
package tpc_pkg;

  // ********************************************************************
  // Widths
  // ********************************************************************
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned PRE_W  = 7;

  // ********************************************************************
  // Register offsets
  // ********************************************************************
  localparam logic [3:0] OFS_CNT_HI = 4'h0;
  localparam logic [3:0] OFS_CNT_LO = 4'h1;
  localparam logic [3:0] OFS_RLD_HI = 4'h2;
  localparam logic [3:0] OFS_RLD_LO = 4'h3;
  localparam logic [3:0] OFS_PWM_HI = 4'h4;
  localparam logic [3:0] OFS_PWM_LO = 4'h5;
  localparam logic [3:0] OFS_CTL0   = 4'h6;
  localparam logic [3:0] OFS_CTL1   = 4'h7;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int unsigned CTL1_EN_BIT   = 7;
  localparam int unsigned CTL1_POL_BIT  = 6;
  localparam int unsigned CTL1_PRE_LSB  = 3;
  localparam int unsigned CTL1_MODE_LSB = 0;
  localparam int unsigned CTL0_OUT_BIT  = 0;

  // ********************************************************************
  // Reset and restart values
  // ********************************************************************
  localparam logic [15:0] CNT_RST     = 16'h0001;
  localparam logic [15:0] CNT_RESTART = 16'h0001;
  localparam logic [15:0] RLD_RST     = 16'hffff;
  localparam logic [15:0] PWM_RST     = 16'h0000;
  localparam logic [7:0]  CTL0_RST    = 8'h00;
  localparam logic [7:0]  CTL1_RST    = 8'h00;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [6:0]  PRE_ZERO    = 7'h00;

  // ********************************************************************
  // Modes
  // ********************************************************************
  typedef enum logic [2:0] {
    TPC_MODE_ONESHOT = 3'h0,
    TPC_MODE_CONT    = 3'h1,
    TPC_MODE_COUNTER = 3'h2,
    TPC_MODE_PWM     = 3'h3,
    TPC_MODE_CAPTURE = 3'h4,
    TPC_MODE_COMPARE = 3'h5,
    TPC_MODE_GATED   = 3'h6,
    TPC_MODE_CAPCMP  = 3'h7
  } tpc_mode_t;

endpackage

//--- verilog/tpc_timer.sv
`timescale 1ns/10ps
module tpc_timer
  import tpc_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic              rst_n_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  input  wire logic              timer_in,
  output logic      [DATA_W-1:0] rd_data_out,
  output logic                   timer_out,
  output logic                   irq_out
);

  // ********************************************************************
  // State
  // ********************************************************************
  logic [CNT_W-1:0]  cnt_q,      cnt_d;
  logic [CNT_W-1:0]  rld_q,      rld_d;
  logic [CNT_W-1:0]  pwm_q,      pwm_d;
  logic [DATA_W-1:0] rld_hold_q, rld_hold_d;
  logic [DATA_W-1:0] lo_hold_q,  lo_hold_d;
  logic [DATA_W-1:0] ctl0_q,     ctl0_d;
  logic [DATA_W-1:0] ctl1_q,     ctl1_d;
  logic [DATA_W-1:0] rd_data_q,  rd_data_d;
  logic [PRE_W-1:0]  pre_q,      pre_d;
  logic              tout_q,     tout_d;
  logic              pin_q,      pin_d;
  logic              irq_q,      irq_d;
  logic              started_q,  started_d;
  logic              tin_q,      tin_d;
  logic              tin_prev_q, tin_prev_d;

  // ********************************************************************
  // Decoded control
  // ********************************************************************
  logic              en;
  logic              pol;
  logic [2:0]        pre_sel;
  tpc_mode_t         mode;
  logic [PRE_W-1:0]  pre_last;
  logic              tick;
  logic              rise;
  logic              fall;
  logic              edge_sel;
  logic              active;
  logic              gate_fall;
  logic              cap_now;
  logic [CNT_W-1:0]  cnt_inc;
  logic              wr_cnt;

  assign en       = ctl1_q[CTL1_EN_BIT];
  assign pol      = ctl1_q[CTL1_POL_BIT];
  assign pre_sel  = ctl1_q[CTL1_PRE_LSB +: 3];
  assign mode     = tpc_mode_t'(ctl1_q[CTL1_MODE_LSB +: 3]);
  // Divide by 2**pre_sel, so 1 up to 128
  assign pre_last = PRE_W'((8'h01 << pre_sel) - 8'h01);
  assign tick     = en && (pre_q == pre_last);
  // Edges are seen on the registered copy, one cycle after the pin
  assign rise      = tin_q && !tin_prev_q;
  assign fall      = !tin_q && tin_prev_q;
  assign edge_sel  = pol ? fall : rise;
  assign active    = tin_q ^ pol;
  assign gate_fall = (tin_prev_q ^ pol) && !active;
  assign cnt_inc   = cnt_q + 16'h0001;
  assign wr_cnt    = wr_in && (addr_in == OFS_CNT_HI || addr_in == OFS_CNT_LO);
  assign cap_now   = en && edge_sel && ((mode == TPC_MODE_CAPTURE) ||
                     (mode == TPC_MODE_CAPCMP && started_q));

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    cnt_d      = cnt_q;
    rld_d      = rld_q;
    pwm_d      = pwm_q;
    rld_hold_d = rld_hold_q;
    lo_hold_d  = lo_hold_q;
    ctl0_d     = ctl0_q;
    ctl1_d     = ctl1_q;
    rd_data_d  = BYTE_ZERO;
    tout_d     = tout_q;
    irq_d      = 1'b0;
    started_d  = started_q;
    tin_d      = timer_in;
    tin_prev_d = tin_q;
    pre_d      = (!en || tick) ? PRE_ZERO : PRE_W'(pre_q + 7'h01);
    if (!en) begin
      // Idle output sits at the polarity level, ready for the first period
      tout_d    = pol;
      started_d = 1'b0;
    end else begin
      unique case (mode)
        TPC_MODE_PWM: begin
          if (tick) begin
            if (cnt_q == rld_q) begin
              cnt_d  = CNT_RESTART;
              irq_d  = 1'b1;
              tout_d = pol;
            end else begin
              cnt_d = cnt_inc;
              if (cnt_q == pwm_q) begin
                tout_d = ~pol;
              end
            end
          end
        end
        TPC_MODE_CAPTURE: begin
          if (tick) begin
            cnt_d = cnt_inc;
            if (cnt_q == rld_q) begin
              irq_d = 1'b1;
            end
          end
          if (cap_now) begin
            pwm_d = cnt_q;
            irq_d = 1'b1;
          end
        end
        TPC_MODE_COMPARE: begin
          if (tick) begin
            cnt_d = cnt_inc;
            if (cnt_q == rld_q) begin
              irq_d  = 1'b1;
              tout_d = ~tout_q;
            end
          end
        end
        TPC_MODE_GATED: begin
          if (tick && active) begin
            if (cnt_q == rld_q) begin
              cnt_d  = CNT_RESTART;
              irq_d  = 1'b1;
              tout_d = ~tout_q;
            end else begin
              cnt_d = cnt_inc;
            end
          end
          if (gate_fall) begin
            irq_d = 1'b1;
          end
        end
        TPC_MODE_CAPCMP: begin
          if (!started_q) begin
            if (edge_sel) begin
              started_d = 1'b1;
            end
          end else if (cap_now) begin
            // Edge beats a same-cycle compare match
            pwm_d = cnt_q;
            irq_d = 1'b1;
            cnt_d = CNT_RESTART;
          end else if (tick) begin
            if (cnt_q == rld_q) begin
              irq_d = 1'b1;
              cnt_d = CNT_RESTART;
            end else begin
              cnt_d = cnt_inc;
            end
          end
        end
        TPC_MODE_ONESHOT, TPC_MODE_CONT, TPC_MODE_COUNTER: begin
          // Not carried by this block: the counter holds
        end
      endcase
    end
    if (wr_in) begin
      unique case (addr_in)
        OFS_CNT_HI: cnt_d[15:8] = wr_data_in;
        OFS_CNT_LO: cnt_d[7:0]  = wr_data_in;
        OFS_RLD_HI: rld_hold_d  = wr_data_in;
        OFS_RLD_LO: rld_d       = {rld_hold_q, wr_data_in};
        OFS_PWM_HI: begin
          // A capture in the same cycle wins over software
          if (!cap_now) begin
            pwm_d[15:8] = wr_data_in;
          end
        end
        OFS_PWM_LO: begin
          if (!cap_now) begin
            pwm_d[7:0] = wr_data_in;
          end
        end
        OFS_CTL0:   ctl0_d = wr_data_in;
        OFS_CTL1:   ctl1_d = wr_data_in;
        default:    ;
      endcase
    end
    if (rd_in) begin
      unique case (addr_in)
        OFS_CNT_HI: begin
          rd_data_d = cnt_q[15:8];
          if (en) begin
            lo_hold_d = cnt_q[7:0];
          end
        end
        OFS_CNT_LO: rd_data_d = en ? lo_hold_q : cnt_q[7:0];
        OFS_RLD_HI: rd_data_d = rld_q[15:8];
        OFS_RLD_LO: rd_data_d = rld_q[7:0];
        OFS_PWM_HI: rd_data_d = pwm_q[15:8];
        OFS_PWM_LO: rd_data_d = pwm_q[7:0];
        OFS_CTL0:   rd_data_d = ctl0_q;
        OFS_CTL1:   rd_data_d = ctl1_q;
        default:    rd_data_d = BYTE_ZERO;
      endcase
    end
    // Pin follows the internal level one cycle later, low while the CTL0 output bit is clear
    pin_d = ctl0_q[CTL0_OUT_BIT] ? tout_q : 1'b0;
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q      <= CNT_RST;
      rld_q      <= RLD_RST;
      pwm_q      <= PWM_RST;
      rld_hold_q <= BYTE_ZERO;
      lo_hold_q  <= BYTE_ZERO;
      ctl0_q     <= CTL0_RST;
      ctl1_q     <= CTL1_RST;
      rd_data_q  <= BYTE_ZERO;
      pre_q      <= PRE_ZERO;
      tout_q     <= 1'b0;
      pin_q      <= 1'b0;
      irq_q      <= 1'b0;
      started_q  <= 1'b0;
      tin_q      <= 1'b0;
      tin_prev_q <= 1'b0;
    end else begin
      cnt_q      <= cnt_d;
      rld_q      <= rld_d;
      pwm_q      <= pwm_d;
      rld_hold_q <= rld_hold_d;
      lo_hold_q  <= lo_hold_d;
      ctl0_q     <= ctl0_d;
      ctl1_q     <= ctl1_d;
      rd_data_q  <= rd_data_d;
      pre_q      <= pre_d;
      tout_q     <= tout_d;
      pin_q      <= pin_d;
      irq_q      <= irq_d;
      started_q  <= started_d;
      tin_q      <= tin_d;
      tin_prev_q <= tin_prev_d;
    end
  end

  assign rd_data_out = rd_data_q;
  assign timer_out   = pin_q;
  assign irq_out     = irq_q;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  pwm_reload_a: assert property (
    (en && mode == TPC_MODE_PWM && tick && cnt_q == rld_q && !wr_cnt)
      |=> (cnt_q == CNT_RESTART && irq_out && tout_q == $past(pol)))
    else $error("pwm reload did not restart the count");

  pwm_match_a: assert property (
    (en && mode == TPC_MODE_PWM && tick && cnt_q == pwm_q && cnt_q != rld_q
      && !wr_in) |=> (tout_q == !$past(pol)) ##1
      (timer_out == (ctl0_q[CTL0_OUT_BIT] && !$past(pol, 2))))
    else $error("pwm match did not move the output");

  cap_copy_a: assert property (
    (cap_now && mode == TPC_MODE_CAPTURE)
      |=> (pwm_q == $past(cnt_q) && irq_out))
    else $error("capture did not copy the count");

  cap_run_a: assert property (
    (cap_now && mode == TPC_MODE_CAPTURE && tick && !wr_cnt)
      |=> (cnt_q == $past(cnt_q) + 16'h0001))
    else $error("capture disturbed the counter");

  cmp_wrap_a: assert property (
    (en && mode == TPC_MODE_COMPARE && tick && cnt_q == 16'hffff && !wr_cnt)
      |=> (cnt_q == 16'h0000))
    else $error("compare counter did not wrap");

  gate_hold_a: assert property (
    (en && mode == TPC_MODE_GATED && !active && !wr_cnt) |=> $stable(cnt_q))
    else $error("gated counter moved while input inactive");

  gate_irq_a: assert property (
    (en && mode == TPC_MODE_GATED && $fell(active)) |=> irq_out)
    else $error("gate release gave no interrupt");

  cc_first_a: assert property (
    (en && mode == TPC_MODE_CAPCMP && !started_q && edge_sel && !wr_cnt)
      |=> (!irq_out && started_q && $stable(cnt_q)))
    else $error("first capture edge misbehaved");

  tick_only_a: assert property (
    (!$past(tick) && !$past(wr_cnt) && !$past(cap_now)) |-> $stable(cnt_q))
    else $error("counter moved without a prescaled tick");

  hold_read_a: assert property (
    (rd_in && addr_in == OFS_CNT_HI && en) ##1 (rd_in && addr_in == OFS_CNT_LO
      && en) |=> (rd_data_out == $past(cnt_q[7:0], 2)))
    else $error("low byte read missed the held value");

  rld_wait_a: assert property (
    (wr_in && addr_in == OFS_RLD_HI) |=> $stable(rld_q))
    else $error("reload changed on a high byte write");

  cap_reload_a: assert property (
    (en && mode == TPC_MODE_CAPTURE && tick && cnt_q == rld_q && !wr_cnt)
      |=> (irq_out && cnt_q == $past(cnt_q) + 16'h0001))
    else $error("capture reload did not interrupt and count on");

  cmp_match_a: assert property (
    (en && mode == TPC_MODE_COMPARE && tick && cnt_q == rld_q && !wr_cnt)
      |=> (irq_out && cnt_q == $past(cnt_q) + 16'h0001 && tout_q != $past(tout_q)))
    else $error("compare match misbehaved");

  cc_restart_a: assert property (
    (cap_now && mode == TPC_MODE_CAPCMP && !wr_cnt)
      |=> (cnt_q == CNT_RESTART && irq_out && pwm_q == $past(cnt_q)))
    else $error("capture edge did not restart the count");

  cc_cmp_a: assert property (
    (en && mode == TPC_MODE_CAPCMP && started_q && !edge_sel && tick
      && cnt_q == rld_q && !wr_cnt) |=> (cnt_q == CNT_RESTART && irq_out))
    else $error("compare match did not restart the count");

  gate_reload_a: assert property (
    (en && mode == TPC_MODE_GATED && tick && active && cnt_q == rld_q && !wr_cnt)
      |=> (cnt_q == CNT_RESTART && irq_out && tout_q != $past(tout_q)))
    else $error("gated reload did not restart the count");

  lo_live_a: assert property (
    (rd_in && addr_in == OFS_CNT_LO && !en) |=> (rd_data_out == $past(cnt_q[7:0])))
    else $error("low byte read while stopped was not live");

  pre_div1_a: assert property (
    (en && tick && pre_sel == 3'h0 && !wr_in) |=> tick)
    else $error("divide by one missed a tick");

endmodule // tpc_timer

//--- bench/tpc_pin_model.sv
`timescale 1ns/10ps
// ************************************************************
// Timer pin partner
// ************************************************************
module tpc_pin_model (
  input  wire logic clk_in,
  input  wire logic out_pin_in,
  output logic      in_pin_out
);
  int   toggles = 0;
  logic last_q  = 1'b0;

  initial in_pin_out = 1'b0;

  // Level changes seen on the output pin
  always @(posedge clk_in) begin
    if (out_pin_in !== last_q) toggles <= toggles + 1;
    last_q <= out_pin_in;
  end

  // Levels hold two cycles or more: the block sees only a registered copy
  task automatic drive(input logic lvl, input int hold);
    @(posedge clk_in);
    in_pin_out <= lvl;
    repeat (hold) @(posedge clk_in);
  endtask
endmodule // tpc_pin_model

//--- bench/tb_timer_pwm_capture_gated_modes.sv
`timescale 1ns/10ps
module tb_timer_pwm_capture_gated_modes
  import tpc_pkg::*;
();
  logic              clk_sys_in = 1'b0;
  logic              rst_n_in   = 1'b0;
  logic [ADDR_W-1:0] addr_in    = '0;
  logic [DATA_W-1:0] wr_data_in = '0;
  logic              wr_in      = 1'b0;
  logic              rd_in      = 1'b0;
  logic              timer_in;
  logic [DATA_W-1:0] rd_data_out;
  logic              timer_out;
  logic              irq_out;
  int                err_count  = 0;
  int                checks     = 0;
  int                cyc        = 0;
  int                t0;
  int                irq_q[$];
  logic              out_q[$];

  always #4 clk_sys_in = ~clk_sys_in;

  tpc_timer u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .timer_in(timer_in),
    .rd_data_out(rd_data_out), .timer_out(timer_out), .irq_out(irq_out));

  tpc_pin_model u_pin (.clk_in(clk_sys_in), .out_pin_in(timer_out), .in_pin_out(timer_in));

  // Cycle-indexed history so periods can be measured without guessing latency
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    out_q.push_back(timer_out);
    if (irq_out === 1'b1) irq_q.push_back(cyc);
  end

  // ************************************************************
  // Bus and check tasks
  // ************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in    <= a;
    wr_data_in <= d;
    wr_in      <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 d = rd_data_out;
  endtask

  // High then low count byte with no gap between the strobes
  task automatic rd_cnt_pair(output logic [15:0] v);
    @(posedge clk_sys_in);
    addr_in <= OFS_CNT_HI;
    rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    addr_in <= OFS_CNT_LO;
    #1 v[15:8] = rd_data_out;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 v[7:0] = rd_data_out;
  endtask

  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 4'h1, v[7:0]);
  endtask

  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    rd(a, v[15:8]);
    rd(a + 4'h1, v[7:0]);
  endtask

  task automatic wait_irqs(input int n, input int lim);
    repeat (lim) if (irq_q.size() < n) @(posedge clk_sys_in);
  endtask

  // Disable, program everything, enable last
  task automatic cfg(input tpc_mode_t m, input logic p, input logic [2:0] s,
                     input logic [15:0] st, rl, pw, input logic oe);
    wr(OFS_CTL1, {1'b0, p, s, m});
    wr16(OFS_CNT_HI, st);
    wr16(OFS_PWM_HI, pw);
    wr16(OFS_RLD_HI, rl);
    wr(OFS_CTL0, {7'h00, oe});
    wr(OFS_CTL1, {1'b1, p, s, m});
    t0 = cyc;
    irq_q.delete();
  endtask

  // Reload 8, match 5: any full period window holds the exact high time
  task automatic pwm_run(input logic p, input logic [2:0] s, input logic [15:0] st,
                         output int lat);
    int hi = 0;
    cfg(TPC_MODE_PWM, p, s, st, 16'h0008, 16'h0005, 1'b1);
    chk({15'h0, timer_out}, {15'h0, p});
    wait_irqs(3, 4000);
    chk(16'(irq_q.size()), 16'h0003);
    lat = irq_q[0] - t0;
    for (int i = irq_q[1]; i < irq_q[2]; i++) hi += out_q[i];
    chk(16'(irq_q[2] - irq_q[1]), 16'(8 << s));
    chk(16'(hi), 16'((p ? 5 : 3) << s));
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk_sys_in);
    err_count++;
    give_verdict();
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    logic [15:0] v, c2;
    logic [7:0]  b, l1;
    int          la, lb, tg;
    static logic [7:0] rst_v [9] = '{8'h00, 8'h01, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00,
                                     8'h00, 8'h00};
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    // Reset values, plus one unmapped address
    for (int i = 0; i < 9; i++) begin
      rd(4'(i), b);
      chk({8'h00, b}, {8'h00, rst_v[i]});
    end
    wr(OFS_RLD_HI, 8'h12);
    rd16(OFS_RLD_HI, v);
    chk(v, 16'hffff);
    wr(OFS_RLD_LO, 8'h34);
    rd16(OFS_RLD_HI, v);
    chk(v, 16'h1234);
    pwm_run(1'b0, 3'h0, 16'h0001, la);
    pwm_run(1'b1, 3'h0, 16'h0003, lb);
    chk(16'(la - lb), 16'h0002);
    pwm_run(1'b0, 3'h7, 16'h0001, la);
    cfg(TPC_MODE_CAPTURE, 1'b0, 3'h0, 16'h0001, 16'h0040, 16'h0000, 1'b0);
    wait_irqs(1, 100);
    rd16(OFS_PWM_HI, v);
    chk(v, 16'h0000);
    u_pin.drive(1'b1, 4);
    rd16(OFS_PWM_HI, v);
    u_pin.drive(1'b0, 4);
    u_pin.drive(1'b1, 4);
    rd16(OFS_PWM_HI, c2);
    chk(c2 - v, 16'd14);
    chk(16'(irq_q.size()), 16'h0003);
    rd16(OFS_CNT_HI, v);
    chk({15'h0, v > c2}, 16'h0001);
    tg = u_pin.toggles;
    cfg(TPC_MODE_COMPARE, 1'b0, 3'h0, 16'hfff0, 16'h0004, 16'h0000, 1'b1);
    wait_irqs(1, 40);
    chk(16'(irq_q.size()), 16'h0001);
    rd16(OFS_CNT_HI, v);
    chk({15'h0, v > 16'h0004 && v < 16'h0010}, 16'h0001);
    chk(16'(u_pin.toggles - tg), 16'h0001);
    rd(OFS_CNT_HI, b);
    repeat (30) @(posedge clk_sys_in);
    rd(OFS_CNT_LO, l1);
    rd(OFS_CNT_HI, b);
    rd(OFS_CNT_LO, b);
    chk({8'h00, b - l1}, 16'd34);
    // Gate must be inactive at enable, or the count runs before it is checked
    u_pin.drive(1'b0, 4);
    cfg(TPC_MODE_GATED, 1'b0, 3'h0, 16'h0001, 16'h0010, 16'h0000, 1'b1);
    repeat (10) @(posedge clk_sys_in);
    rd16(OFS_CNT_HI, v);
    chk(v, 16'h0001);
    tg = u_pin.toggles;
    u_pin.drive(1'b1, 9);
    u_pin.drive(1'b0, 6);
    chk(16'(irq_q.size()), 16'h0001);
    rd_cnt_pair(v);
    chk(v, 16'h000b);
    u_pin.drive(1'b1, 19);
    u_pin.drive(1'b0, 6);
    chk(16'(irq_q.size()), 16'h0003);
    rd16(OFS_CNT_HI, v);
    chk(v, 16'h000f);
    chk(16'(u_pin.toggles - tg), 16'h0001);
    u_pin.drive(1'b1, 4);
    cfg(TPC_MODE_CAPCMP, 1'b1, 3'h0, 16'h0001, 16'h0100, 16'h0000, 1'b0);
    repeat (10) @(posedge clk_sys_in);
    rd16(OFS_CNT_HI, v);
    chk(v, 16'h0001);
    u_pin.drive(1'b0, 4);
    u_pin.drive(1'b1, 4);
    chk(16'(irq_q.size()), 16'h0000);
    u_pin.drive(1'b0, 4);
    u_pin.drive(1'b1, 4);
    u_pin.drive(1'b0, 4);
    rd16(OFS_PWM_HI, c2);
    u_pin.drive(1'b1, 9);
    u_pin.drive(1'b0, 4);
    rd16(OFS_PWM_HI, v);
    chk(v - c2, 16'd9);
    chk(16'(irq_q.size()), 16'h0003);
    cfg(TPC_MODE_CAPCMP, 1'b1, 3'h0, 16'h0001, 16'h0020, 16'h0000, 1'b0);
    u_pin.drive(1'b1, 4);
    u_pin.drive(1'b0, 4);
    wait_irqs(2, 120);
    chk(16'(irq_q[1] - irq_q[0]), 16'h0020);
    give_verdict();
  end
endmodule // tb_timer_pwm_capture_gated_modes
